// ==== packer_pkg.sv ====
// shared constants and types for the compressed audio packer
package packer_pkg;
	// output placement modes
	typedef enum logic [1:0] {
		dual_pro_mode,
		left_only_pro_mode,
		right_only_pro_mode,
		consumer_mode
	} out_mode_t;

	localparam int unsigned SYS_HZ         = 50_000_000; // core clock
	localparam int unsigned SAMPLE_HZ      = 48_000;     // serial frame rate
	localparam int unsigned BURST_HZ       = 32;         // compressed frame rate
	localparam int unsigned WORD_BITS      = 16;         // payload word width
	localparam int unsigned FRAME_WORDS    = 1536;       // payload words/frame
	localparam int unsigned SAMPLE_CYCLES  = SYS_HZ / SAMPLE_HZ;
	localparam int unsigned SAMPLES_PER_BURST = SAMPLE_HZ / BURST_HZ;
	localparam int unsigned FIFO_DEPTH     = 16;         // input buffer depth

	// register map (byte addresses)
	localparam logic [7:0] CTRL_ADDR   = 8'h00; // mode select, enable
	localparam logic [7:0] STATUS_ADDR = 8'h04; // live state
	localparam logic [7:0] COUNT_ADDR  = 8'h08; // frames sent
	// control fields
	localparam int unsigned CTRL_MODE_LSB = 0;  // two bits of mode
	localparam int unsigned CTRL_EN_BIT   = 2;  // packer enable
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

	// one stereo sample as handed to the transmitter
	typedef struct packed {
		logic [15:0] left;      // left subframe word
		logic [15:0] right;     // right subframe word
		logic        non_audio; // channel status audio/non-audio
		logic        pro;       // professional status flag
	} sample_t;
endpackage

// ==== word_fifo.sv ====
// parameterised valid/ready fifo
module word_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  flush_done
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];    // storage
	logic [AW:0]      wp_r, wp_nxt;     // write pointer
	logic [AW:0]      rp_r, rp_nxt;     // read pointer
	logic             push, pop;

	// pointer arithmetic
	always_comb begin
		push   = in_valid && in_ready;
		pop    = out_valid && out_ready;
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
	end

	assign in_ready  = (wp_r - rp_r) != (AW+1)'(DEPTH); // not full
	assign out_valid = wp_r != rp_r;                     // not empty
	assign out_data  = mem_r[rp_r[AW-1:0]];
	assign flush_done = 1'b0;

	// pointers
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
		end
	end

	// storage, no reset
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_r[wp_r[AW-1:0]] <= in_data;
		end
	end
endmodule

// ==== compressed_audio_spdif_packer.sv ====
// packs compressed 16-bit words into stereo samples with zero padding
// How it works
// - dual pro mode alternates words left then right
// - zeros follow frame until the frame period ends
// - left-only mode: words left, right passes pcm
// - right-only mode: words right, left passes pcm
// - consumer mode like dual, consumer status flag
// - fixed 48 kHz samples, two 16-bit channels
// - exactly 1536 payload words per frame in dual and consumer modes, at most 1499 in left-only and right-only modes
// - non-audio flag set while carrying compressed data
// - one burst per 32 Hz frame period
module compressed_audio_spdif_packer
	import packer_pkg::*;
#(
	parameter int unsigned SAMPLE_DIV = SAMPLE_CYCLES,    // clocks per sample
	parameter int unsigned PERIOD_SMP = SAMPLES_PER_BURST, // samples per period
	parameter int unsigned BURST_LEN  = FRAME_WORDS       // words per frame
) (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hsel,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        word_valid,
	output logic             word_ready,
	input  wire logic [15:0] word_data,
	input  wire logic [15:0] pcm_left,
	input  wire logic [15:0] pcm_right,
	output sample_t          sample_out,
	output logic             sample_strobe
);
	typedef enum logic [1:0] {IDLE_ST, BURST_ST, PAD_ST} pk_state_t;

	// bus registers
	logic [31:0] ctrl_r, ctrl_nxt;      // control register
	logic [15:0] frames_r, frames_nxt;  // completed bursts
	logic        wr_pend_r, wr_pend_nxt; // write data phase pending
	logic [7:0]  wr_addr_r, wr_addr_nxt; // latched write address
	logic [31:0] rd_r, rd_nxt;          // read data
	logic        bus_go;

	// packer state
	pk_state_t   st_r, st_nxt;          // burst state
	out_mode_t   mode_r, mode_nxt;      // mode held for frame
	logic [15:0] div_r, div_nxt;        // sample clock divider
	logic [15:0] per_r, per_nxt;        // sample within period
	logic [11:0] wcnt_r, wcnt_nxt;      // words sent in frame
	sample_t     smp_r, smp_nxt;        // output sample
	logic        stb_r, stb_nxt;        // sample pulse
	logic        pair_r, pair_nxt;      // left word taken, right word due
	logic        fifo_valid, fifo_pop;
	logic [15:0] fifo_data;
	logic        tick, period_end;
	logic        left_take, right_take;

	// wide mode decode used three times
	function automatic logic is_pair(input out_mode_t m);
		return m == dual_pro_mode || m == consumer_mode;
	endfunction

	// input buffer
	word_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk    (sys_clk),
		.reset_n    (reset_n),
		.in_valid   (word_valid),
		.in_ready   (word_ready),
		.in_data    (word_data),
		.out_valid  (fifo_valid),
		.out_ready  (fifo_pop),
		.out_data   (fifo_data),
		.flush_done ()
	);

	assign hreadyout     = 1'b1;    // zero wait states
	assign hresp         = 1'b0;    // always okay
	assign hrdata        = rd_r;
	assign sample_out    = smp_r;
	assign sample_strobe = stb_r;
	assign bus_go        = hsel && hready && htrans[1];

	// bus next state
	always_comb begin
		ctrl_nxt    = ctrl_r;
		wr_pend_nxt = bus_go && hwrite;
		wr_addr_nxt = haddr[7:0];
		rd_nxt      = rd_r;
		if (wr_pend_r && wr_addr_r == CTRL_ADDR) begin
			ctrl_nxt = {29'h0, hwdata[2:0]}; // mode and enable
		end
		if (bus_go && !hwrite) begin
			unique case (haddr[7:0])
				CTRL_ADDR:   rd_nxt = ctrl_r;
				STATUS_ADDR: rd_nxt = {16'h0, 2'h0, wcnt_r,
					mode_r};
				COUNT_ADDR:  rd_nxt = {16'h0, frames_r};
				default:     rd_nxt = 32'h0; // unmapped read zero
			endcase
		end
	end

	// bus registers
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r    <= CTRL_RESET;
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			rd_r      <= 32'h0;
		end else begin
			ctrl_r    <= ctrl_nxt;
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			rd_r      <= rd_nxt;
		end
	end

	// sample timing and word placement
	always_comb begin
		st_nxt     = st_r;
		mode_nxt   = mode_r;
		frames_nxt = frames_r;
		div_nxt    = div_r + 16'h1;
		per_nxt    = per_r;
		wcnt_nxt   = wcnt_r;
		smp_nxt    = smp_r;
		stb_nxt    = 1'b0;
		pair_nxt   = 1'b0;
		fifo_pop   = 1'b0;
		left_take  = 1'b0;
		right_take = 1'b0;
		tick       = div_r == 16'(SAMPLE_DIV - 1);
		period_end = per_r == 16'(PERIOD_SMP - 1);
		if (tick) begin
			div_nxt = 16'h0;
			per_nxt = period_end ? 16'h0 : per_r + 16'h1;
			stb_nxt = 1'b1;
			smp_nxt.left  = pcm_left;
			smp_nxt.right = pcm_right;
			// frame boundary: latch mode, burst opens the next period when enabled
			if (period_end) begin
				mode_nxt = out_mode_t'(ctrl_r[1:0]);
				st_nxt   = ctrl_r[CTRL_EN_BIT] ? BURST_ST : IDLE_ST;
				wcnt_nxt = 12'h0;
			end
			if (st_r != IDLE_ST) begin
				smp_nxt.non_audio = 1'b1;
				smp_nxt.pro = mode_r != consumer_mode;
				// zero padding by default in carrying subframes
				if (mode_r != right_only_pro_mode) begin
					smp_nxt.left = 16'h0;
				end
				if (mode_r != left_only_pro_mode) begin
					smp_nxt.right = 16'h0;
				end
				if (st_r == BURST_ST && !period_end) begin
					left_take  = mode_r == left_only_pro_mode ||
						is_pair(mode_r);
					right_take = mode_r == right_only_pro_mode ||
						is_pair(mode_r);
					if (left_take && fifo_valid) begin
						smp_nxt.left = fifo_data;
					end
					// no second word in same cycle; pair uses count
				end
			end else begin
				smp_nxt.non_audio = 1'b0;
				smp_nxt.pro       = 1'b0;
			end
		end
		// one word per cycle from fifo: left on tick, right next cycle in pair modes, on tick in right-only
		if (tick && left_take && fifo_valid) begin
			fifo_pop = 1'b1;
			wcnt_nxt = wcnt_r + 12'h1;
			pair_nxt = is_pair(mode_r); // right word follows
		end
		// in pair modes, right word only after a left word of the same sample
		if (st_r == BURST_ST && pair_r && fifo_valid &&
			wcnt_r != 12'(BURST_LEN)) begin
			fifo_pop        = 1'b1;
			smp_nxt.right   = fifo_data;
			wcnt_nxt        = wcnt_r + 12'h1;
		end
		if (tick && !left_take && right_take && fifo_valid) begin
			fifo_pop      = 1'b1;
			smp_nxt.right = fifo_data;
			wcnt_nxt      = wcnt_r + 12'h1;
		end
		// full frame sent: pad until period ends
		if (st_r == BURST_ST && wcnt_nxt == 12'(BURST_LEN)) begin
			st_nxt     = PAD_ST;
			frames_nxt = frames_r + 16'h1;
		end
	end

	// packer registers
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r     <= IDLE_ST;
			mode_r   <= dual_pro_mode;
			frames_r <= 16'h0;
			div_r    <= 16'h0;
			per_r    <= 16'h0;
			wcnt_r   <= 12'h0;
			smp_r    <= '0;
			stb_r    <= 1'b0;
			pair_r   <= 1'b0;
		end else begin
			st_r     <= st_nxt;
			mode_r   <= mode_nxt;
			frames_r <= frames_nxt;
			div_r    <= div_nxt;
			per_r    <= per_nxt;
			wcnt_r   <= wcnt_nxt;
			smp_r    <= smp_nxt;
			stb_r    <= stb_nxt;
			pair_r   <= pair_nxt;
		end
	end

	// strobe is followed by at least two cycles without strobe
	strobe_space_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		stb_r |=> !stb_r [*2]) else $error("strobe too close");
	// words never exceed frame count
	frame_cap_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		wcnt_r <= 12'(BURST_LEN)) else $error("frame overrun");
	// carrying implies non-audio
	non_audio_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		stb_r && st_r == BURST_ST && $past(st_r) == BURST_ST
		|-> smp_r.non_audio) else $error("audio flag set");
	// mode only moves at a period boundary
	mode_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$changed(mode_r) |-> $past(period_end || st_r == IDLE_ST))
		else $error("mode changed mid frame");
	// left-only leaves right as pcm
	left_only_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		tick && mode_r == left_only_pro_mode && st_r != IDLE_ST
		|=> smp_r.right == $past(pcm_right)) else $error("right touched");
	// right-only leaves left as pcm
	right_only_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		tick && mode_r == right_only_pro_mode && st_r != IDLE_ST
		|=> smp_r.left == $past(pcm_left)) else $error("left touched");
	// padding carries zeros in dual pro mode
	pad_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		tick && st_r == PAD_ST && mode_r == dual_pro_mode
		|=> smp_r.left == 16'h0 && smp_r.right == 16'h0)
		else $error("pad not zero");
	// consumer mode clears pro flag
	consumer_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		tick && mode_r == consumer_mode && st_r != IDLE_ST
		|=> !smp_r.pro) else $error("pro flag in consumer");
	// burst ends with counter reaching frame size
	burst_end_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		st_r == BURST_ST ##1 st_r == PAD_ST |-> wcnt_r == 12'(BURST_LEN))
		else $error("short burst");
	// period wraps
	period_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		per_r < 16'(PERIOD_SMP)) else $error("period overrun");
endmodule

// ==== spdif_sink.sv ====
// receiving end model: records up to 2048 stereo samples the packer sends
module spdif_sink
	import packer_pkg::*;
(
	input  wire logic    sys_clk,
	input  wire logic    reset_n,
	input  wire sample_t sample_out,
	input  wire logic    sample_strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	sample_t     mem [0:2047]; // captured samples in order
	int          count;        // samples captured so far
	logic [15:0] gap;          // cycles between the last two strobes
	logic [15:0] since;        // cycles since the last strobe
	logic [1:0]  dly;          // strobe delay, lets the right word land
	// capture two cycles after each strobe, once both words have settled
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= 0;
			dly   <= 2'h0;
			since <= 16'h0000;
			gap   <= 16'h0000;
		end else begin
			dly   <= {dly[0], sample_strobe};
			since <= sample_strobe ? 16'h0001 : since + 16'h0001;
			// strobe spacing, judged by the bench
			if (sample_strobe)
				gap <= since;
			if (dly[1] && count < 2048) begin
				mem[count] <= sample_out;
				count      <= count + 1;
			end
		end
	end
endmodule

// ==== compressed_audio_spdif_packer_tb.sv ====
// self-checking bench for the compressed audio packer
module compressed_audio_spdif_packer_tb;
	import packer_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DIV = 8;  // clocks per sample, shortened
	localparam int PER = 40; // samples per frame period, shortened
	localparam int BL  = 16; // words per frame, shortened
	logic        sys_clk    = 1'b0;
	logic        reset_n    = 1'b0;
	logic [31:0] haddr      = 32'h0;
	logic [1:0]  htrans     = 2'h0;
	logic        hwrite     = 1'b0;
	logic [2:0]  hsize      = 3'h2;
	logic        hsel       = 1'b0;
	logic [31:0] hwdata     = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        word_valid = 1'b0;
	logic        word_ready;
	logic [15:0] word_data  = 16'h0;
	logic [15:0] pcm_left   = 16'h1111; // filler for a free left slot
	logic [15:0] pcm_right  = 16'h2222; // filler for a free right slot
	sample_t     sample_out;
	logic        sample_strobe;
	int          errors     = 0;
	int          n_checks   = 0;
	// 50 MHz clock
	always #10 sys_clk = ~sys_clk;
	compressed_audio_spdif_packer #(
		.SAMPLE_DIV(DIV), .PERIOD_SMP(PER), .BURST_LEN(BL)
	) dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hsel(hsel),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .word_valid(word_valid),
		.word_ready(word_ready), .word_data(word_data),
		.pcm_left(pcm_left), .pcm_right(pcm_right),
		.sample_out(sample_out), .sample_strobe(sample_strobe)
	);
	spdif_sink sink (
		.sys_clk(sys_clk), .reset_n(reset_n),
		.sample_out(sample_out), .sample_strobe(sample_strobe)
	);
	// one comparison, counted
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask
	// single word bus transfer, waits on hready in both phases
	task automatic ahb(input logic wr, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge sys_clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		hsize  <= 3'h2;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// offer one compressed word, hold until taken
	task automatic push(input logic [15:0] d);
		@(posedge sys_clk);
		word_valid <= 1'b1;
		word_data  <= d;
		do @(posedge sys_clk); while (word_ready !== 1'b1);
		word_valid <= 1'b0;
	endtask
	// reset value, stored bits and an unmapped place
	task automatic test_regs;
		logic [31:0] rd;
		ahb(1'b0, 32'(CTRL_ADDR), 32'h0, rd);
		check(34'(rd), 34'(CTRL_RESET));
		check(34'(hresp), 34'h0); // always okay
		ahb(1'b1, 32'(CTRL_ADDR), 32'hffff_fffb, rd);
		ahb(1'b0, 32'(CTRL_ADDR), 32'h0, rd);
		check(34'(rd), 34'h3);
		ahb(1'b0, 32'h0000_000c, 32'h0, rd);
		check(34'(rd), 34'h0);
		ahb(1'b1, 32'(CTRL_ADDR), 32'h0, rd);
	endtask
	// fill the fifo, run two frames in one mode, judge placement
	task automatic test_mode(input out_mode_t m);
		logic [31:0] rd;
		logic [15:0] wb;
		sample_t     e;
		int          k, s, o, w, wps, base;
		wb   = 16'h8000 | {6'h00, m, 8'h00};
		wps  = (m == left_only_pro_mode || m == right_only_pro_mode) ? 1 : 2;
		for (s = 0; s < BL; s++)
			push(wb + s[15:0]);
		@(negedge sys_clk);
		check(34'(word_ready), 34'h0); // full fifo refuses
		base = sink.count;
		ahb(1'b1, 32'(CTRL_ADDR), {29'h0, 1'b1, m}, rd);
		for (s = BL; s < 2 * BL; s++)
			push(wb + s[15:0]);
		repeat (3 * PER * DIV) @(posedge sys_clk);
		ahb(1'b0, 32'(STATUS_ADDR), 32'h0, rd);
		check(34'(rd[1:0]), 34'(m));
		ahb(1'b0, 32'(COUNT_ADDR), 32'h0, rd);
		check(34'(rd), 34'(2 * (int'(m) + 1)));
		ahb(1'b1, 32'(CTRL_ADDR), 32'h0, rd);
		// let the open period end so the packer is idle again
		repeat ((PER + 1) * DIV) @(posedge sys_clk);
		k = -1;
		for (s = base; s < sink.count; s++)
			if (k < 0 && ((m == right_only_pro_mode) ? sink.mem[s].right
				: sink.mem[s].left) === wb)
				k = s;
		check(34'(k >= 0 && k + 2 * PER <= sink.count), 34'h1);
		// two whole periods: burst words in place, zeros after
		for (s = 0; s < 2 * PER && k >= 0 && k + 2 * PER <= sink.count; s++) begin
			o = s % PER;
			w = (s / PER) * BL + o * wps;
			e.non_audio = 1'b1;
			e.pro       = (m != consumer_mode);
			e.left      = (o < BL / wps) ? wb + w[15:0] : 16'h0;
			e.right     = (o < BL / wps && wps == 2) ? wb + w[15:0] + 16'h1
				: 16'h0;
			if (m == left_only_pro_mode)
				e.right = pcm_right;
			if (m == right_only_pro_mode) begin
				e.right = e.left;
				e.left  = pcm_left;
			end
			check(sink.mem[k + s], e);
		end
		check(34'(sink.gap), 34'(DIV));
		@(negedge sys_clk);
		check(34'(word_ready), 34'h1); // fifo takes words again
	endtask
	// counts, verdict, end of run
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'b1;
		test_regs();
		for (int mi = 0; mi < 4; mi++)
			test_mode(out_mode_t'(mi));
		report_and_stop();
	end
	// watchdog against a hang
	initial begin
		repeat (30000) @(posedge sys_clk);
		errors++;
		report_and_stop();
	end
endmodule
